/* File: snu_cpu_model.sv */
// Register file and exit-condition model of the issuing processor
`timescale 1ns/10ps
module snu_cpu_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Result from the unit
  input wire logic done_i,
  input wire snu_pkg::snu_result_t result_i,
  // Sticky exit conditions
  output logic exit_inf_o,
  output logic exit_ind_o
);
  logic [59:0] word_file [8];
  logic [17:0] count_file [8];

  always_ff @(posedge clk_sys_i) begin
    if (done_i) begin
      word_file[result_i.dest_idx] <= result_i.dest_word;
      if (result_i.cnt_we) begin
        count_file[result_i.cnt_idx] <= result_i.cnt_val;
      end
    end
  end

  // Exit conditions stay set until reset, as exit-mode logic would see them
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      exit_inf_o <= 1'b0;
      exit_ind_o <= 1'b0;
    end else if (done_i) begin
      exit_inf_o <= exit_inf_o | result_i.infinite;
      exit_ind_o <= exit_ind_o | result_i.indefinite;
    end
  end
endmodule // snu_cpu_model

/* File: snu_pkg.sv */
// Package with constants, types and helper functions of the shift and normalize unit
// Behaviour
// - Variable left shift reads a 60-bit word, shifts per count, writes 60-bit result.
// - Left shift with positive count rotates the word left circularly.
// - Left shift with negative count shifts right with sign extension.
// - Count sign comes only from count bit 17 for both variable shifts.
// - Circular shift reinserts top bits at the bottom, keeping the count of ones.
// - Right shift drops low bits and fills the top with copies of bit 59.
// - Left shift: bit 17 set and bits 6-10 differ gives positive zero.
// - Count bits 11 to 16 are ignored by both variable shifts.
// - Right shift with positive count shifts right with sign extension.
// - Right shift with negative count rotates the word left circularly.
// - Right shift: bit 17 clear and bits 6-10 differ gives positive zero.
// - Normalize shifts the coefficient left minimally until bit 47 differs from bit 59.
// - Normalize lowers the exponent by exactly the shift, keeping the value, unless it would fall below the lowest exponent, which gives a zero word.
// - Normalize and round-normalize return the shift as a positive count.
// - Normalize with a zero coefficient above the lowest exponent returns count 48 and a positive zero word.
// - Infinite or indefinite operands are copied, count zero, exit flag raised.
// - Normalize of a zero coefficient with the lowest exponent gives zero word and zero count.
// - Round-normalize rounds first and then normalizes.
// - The round bit sits below the coefficient LSB and equals the inverted sign.
// - The round bit moves left with the coefficient into the vacated bits.
// - Constant shifts take j and k as one unsigned 6-bit amount.
// - Constant left shift rotates the destination word left and writes it back.
package snu_pkg;

  localparam int WORD_W = 60;
  localparam int COEF_W = 48;
  localparam int EXP_W = 11;
  localparam int CNT_W = 18;

  // Field positions
  localparam int SIGN_BIT = 59;
  localparam int EXP_LSB = 48;
  localparam int CNT_SIGN_BIT = 17;
  localparam int CNT_HI_MSB = 10;
  localparam int CNT_HI_LSB = 6;

  // Opcodes
  localparam logic [5:0] OP_CONST_LEFT = 6'h10;
  localparam logic [5:0] OP_CONST_RIGHT = 6'h11;
  localparam logic [5:0] OP_VAR_LEFT = 6'h12;
  localparam logic [5:0] OP_VAR_RIGHT = 6'h13;
  localparam logic [5:0] OP_NORM = 6'h14;
  localparam logic [5:0] OP_RND_NORM = 6'h15;

  // Exponent codes of the positive form and biases
  localparam logic [10:0] EXP_INF = 11'h7ff;
  localparam logic [10:0] EXP_IND = 11'h3ff;
  localparam logic [10:0] EXP_LOWEST = 11'h000;
  localparam logic signed [12:0] EXP_POS_BIAS = 13'sh0400;
  localparam logic signed [12:0] EXP_NEG_BIAS = 13'sh03ff;

  // Zero-coefficient count, rotation modulus and word value after reset
  localparam logic [17:0] CNT_ZERO_COEF = 18'h00030;
  localparam logic [5:0] ROT_MOD = 6'h3c;
  localparam logic [59:0] WORD_RST = 60'h0;

  typedef struct packed {
    logic [5:0] opcode;
    logic [2:0] dest_idx;
    logic [2:0] j;
    logic [2:0] k;
  } snu_instr_t;

  typedef struct packed {
    logic [2:0] dest_idx;
    logic [59:0] dest_word;
    logic cnt_we;
    logic [2:0] cnt_idx;
    logic [17:0] cnt_val;
    logic infinite;
    logic indefinite;
  } snu_result_t;

  // Leading zeros of a coefficient, 48 when it is zero
  function automatic logic [5:0] snu_lead_zeros(input logic [47:0] c);
    logic [5:0] n;
    n = 6'h30;
    for (int i = 0; i < COEF_W; i++) begin
      if (c[i]) begin
        n = 6'(COEF_W - 1 - i);
      end
    end
    return n;
  endfunction

  // Signed exponent of a positive-form biased field
  function automatic logic signed [12:0] snu_exp_val(input logic [10:0] e);
    logic signed [12:0] x;
    x = $signed({2'b00, e});
    return e[10] ? x - EXP_POS_BIAS : x - EXP_NEG_BIAS;
  endfunction

  // Biased field of a signed exponent
  function automatic logic [10:0] snu_exp_pack(input logic signed [12:0] v);
    logic signed [12:0] x;
    x = (v >= 0) ? v + EXP_POS_BIAS : v + EXP_NEG_BIAS;
    return x[10:0];
  endfunction

endpackage

/* File: snu_shift60.sv */
// Sixty-bit left circular or right sign-extending shifter
`timescale 1ns/10ps
module snu_shift60 (
  // Operand
  input wire logic [59:0] word_i,
  input wire logic [5:0] amount_i,
  input wire logic rotate_i,
  // Result
  output logic [59:0] word_o
);

  logic [5:0] rot_amt;
  logic [119:0] doubled;
  logic [119:0] rotated;

  // Amounts of 60 to 63 wrap around the word
  assign rot_amt = (amount_i >= snu_pkg::ROT_MOD) ? amount_i - snu_pkg::ROT_MOD : amount_i;
  assign doubled = {word_i, word_i};
  assign rotated = doubled << rot_amt;

  always_comb begin
    if (rotate_i) begin
      word_o = rotated[119:60];
    end else begin
      word_o = $signed(word_i) >>> amount_i;
    end
  end

endmodule // snu_shift60

/* File: snu_shift_norm.sv */
// Shift and normalize unit with one register stage
`timescale 1ns/10ps
module snu_shift_norm (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Issue
  input wire logic issue_i,
  input wire snu_pkg::snu_instr_t instr_i,
  // Operands
  input wire logic [59:0] source_word_reg_i,
  input wire logic [59:0] dest_word_reg_i,
  input wire logic [17:0] shift_count_reg_i,
  // Result
  output logic done_o,
  output snu_pkg::snu_result_t result_o
);

  // Decode
  logic op_cl;
  logic op_cr;
  logic op_vl;
  logic op_vr;
  logic op_nm;
  logic op_rn;
  logic op_known;

  assign op_cl = instr_i.opcode == snu_pkg::OP_CONST_LEFT;
  assign op_cr = instr_i.opcode == snu_pkg::OP_CONST_RIGHT;
  assign op_vl = instr_i.opcode == snu_pkg::OP_VAR_LEFT;
  assign op_vr = instr_i.opcode == snu_pkg::OP_VAR_RIGHT;
  assign op_nm = instr_i.opcode == snu_pkg::OP_NORM;
  assign op_rn = instr_i.opcode == snu_pkg::OP_RND_NORM;
  assign op_known = op_cl | op_cr | op_vl | op_vr | op_nm | op_rn;

  // Variable count: sign, range bits, magnitude
  logic cnt_neg;
  logic cnt_hi_ok;
  logic [5:0] cnt_mag;

  assign cnt_neg = shift_count_reg_i[snu_pkg::CNT_SIGN_BIT];
  // Bits 11 to 16 take no part
  assign cnt_hi_ok = shift_count_reg_i[10:6] == {5{cnt_neg}};
  assign cnt_mag = cnt_neg ? ~shift_count_reg_i[5:0] : shift_count_reg_i[5:0];

  // Shifter operand selection
  logic [59:0] sh_in;
  logic [5:0] sh_amt;
  logic sh_rot;
  logic sh_oor;
  logic [59:0] sh_out;

  always_comb begin
    sh_in = source_word_reg_i;
    sh_amt = cnt_mag;
    sh_rot = 1'b0;
    sh_oor = 1'b0;
    if (op_cl | op_cr) begin
      sh_in = dest_word_reg_i;
      sh_amt = {instr_i.j, instr_i.k};
      sh_rot = op_cl;
    end else if (op_vl) begin
      sh_rot = ~cnt_neg;
      sh_oor = cnt_neg & ~cnt_hi_ok;
    end else if (op_vr) begin
      sh_rot = cnt_neg;
      sh_oor = ~cnt_neg & ~cnt_hi_ok;
    end
  end

  snu_shift60 u_shift (
    .word_i(sh_in),
    .amount_i(sh_amt),
    .rotate_i(sh_rot),
    .word_o(sh_out)
  );

  // Normalize on the positive form of the operand
  logic op_neg;
  logic [59:0] pos_word;
  logic [10:0] pos_exp;
  logic [47:0] pos_coef;
  logic rnd;
  logic is_inf;
  logic is_ind;
  logic coef_zero;
  logic [5:0] lz;
  logic [48:0] ext_coef;
  logic [48:0] ext_shifted;
  logic signed [12:0] new_exp_val;
  logic underflow;
  logic [59:0] norm_pos;

  assign op_neg = source_word_reg_i[snu_pkg::SIGN_BIT];
  assign pos_word = op_neg ? ~source_word_reg_i : source_word_reg_i;
  assign pos_exp = pos_word[58:48];
  assign pos_coef = pos_word[47:0];
  assign rnd = op_rn;
  assign is_inf = pos_exp == snu_pkg::EXP_INF;
  assign is_ind = pos_exp == snu_pkg::EXP_IND;
  assign coef_zero = (pos_coef == 48'h0) & ~rnd;
  assign lz = snu_pkg::snu_lead_zeros(pos_coef);
  // Round bit is one in positive form, the inverted sign once restored
  assign ext_coef = {pos_coef, rnd};
  assign ext_shifted = ext_coef << lz;
  assign new_exp_val = snu_pkg::snu_exp_val(pos_exp) - $signed({7'h00, lz});
  assign underflow = new_exp_val < -snu_pkg::EXP_NEG_BIAS;
  assign norm_pos = {1'b0, snu_pkg::snu_exp_pack(new_exp_val), ext_shifted[48:1]};

  // Next result
  snu_pkg::snu_result_t next_result;
  logic next_uflow;

  always_comb begin
    next_result = '0;
    next_uflow = 1'b0;
    next_result.dest_idx = instr_i.dest_idx;
    next_result.cnt_idx = instr_i.j;
    if (op_nm | op_rn) begin
      next_result.cnt_we = 1'b1;
      if (is_inf | is_ind) begin
        next_result.dest_word = source_word_reg_i;
        next_result.cnt_val = 18'h0;
        next_result.infinite = is_inf;
        next_result.indefinite = is_ind;
      end else if (coef_zero & (pos_exp == snu_pkg::EXP_LOWEST)) begin
        next_result.dest_word = 60'h0;
        next_result.cnt_val = 18'h0;
      end else if (coef_zero) begin
        next_result.dest_word = 60'h0;
        next_result.cnt_val = snu_pkg::CNT_ZERO_COEF;
      end else begin
        next_result.cnt_val = {12'h000, lz};
        next_uflow = underflow;
        if (underflow) begin
          next_result.dest_word = 60'h0;
        end else begin
          next_result.dest_word = op_neg ? ~norm_pos : norm_pos;
        end
      end
    end else if (sh_oor) begin
      next_result.dest_word = 60'h0;
    end else begin
      next_result.dest_word = sh_out;
    end
  end

  // Result stage
  logic uflow_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= issue_i & op_known;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      result_o <= '0;
      uflow_q <= 1'b0;
    end else if (issue_i & op_known) begin
      result_o <= next_result;
      uflow_q <= next_uflow;
    end else begin
      result_o.cnt_we <= 1'b0;
      result_o.infinite <= 1'b0;
      result_o.indefinite <= 1'b0;
    end
  end

  // Checks on the result stage
  logic iss_vl;
  logic iss_vr;
  logic iss_cl;
  logic iss_nrm;

  assign iss_vl = issue_i & op_vl;
  assign iss_vr = issue_i & op_vr;
  assign iss_cl = issue_i & op_cl;
  assign iss_nrm = issue_i & (op_nm | op_rn);

  a_left_rot_ones: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_vl & ~cnt_neg) |=> done_o && $countones(result_o.dest_word) == $countones($past(source_word_reg_i))
  ) else $error("rotate changed the number of ones");

  a_left_oor_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_vl & cnt_neg & (shift_count_reg_i[10:6] != 5'h1f)) |=> result_o.dest_word == 60'h0
  ) else $error("left op out of range did not give zero");

  a_right_oor_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_vr & ~cnt_neg & (shift_count_reg_i[10:6] != 5'h00)) |=> result_o.dest_word == 60'h0
  ) else $error("right op out of range did not give zero");

  a_right_sign_fill: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_vr & ~cnt_neg & cnt_hi_ok & (cnt_mag != 6'h00))
    |=> result_o.dest_word[59] == $past(source_word_reg_i[59])
      && result_o.dest_word[58] == $past(source_word_reg_i[59])
  ) else $error("right shift did not fill with the sign");

  a_ignore_mid_bits: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_vr & cnt_neg & (shift_count_reg_i[16:11] != 6'h00) & (shift_count_reg_i[10:6] == 5'h1f))
    |=> $countones(result_o.dest_word) == $countones($past(source_word_reg_i))
  ) else $error("negative right op did not rotate");

  a_const_rotate: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    iss_cl |=> result_o.dest_idx == $past(instr_i.dest_idx)
      && $countones(result_o.dest_word) == $countones($past(dest_word_reg_i))
  ) else $error("constant rotate lost bits or register");

  a_norm_msb_set: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_nrm & ~is_inf & ~is_ind & ~coef_zero) ##1 !uflow_q
    |-> result_o.dest_word[47] != result_o.dest_word[59]
  ) else $error("normalized word not normalized");

  a_norm_exp_drop: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_nrm & ~is_inf & ~is_ind & ~coef_zero) ##1 !uflow_q
    |-> snu_pkg::snu_exp_val(result_o.dest_word[59] ? ~result_o.dest_word[58:48] : result_o.dest_word[58:48])
      == $past(new_exp_val)
      && $signed({1'b0, result_o.cnt_val}) == snu_pkg::snu_exp_val($past(pos_exp)) - $past(new_exp_val)
  ) else $error("exponent not lowered by the shift");

  a_zero_coef_48: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_i & op_nm & ~is_inf & ~is_ind & (pos_coef == 48'h0) & (pos_exp != 11'h000))
    |=> result_o.cnt_val == 18'h00030 && result_o.dest_word == 60'h0 && result_o.cnt_we
  ) else $error("zero coefficient not count 48 and zero");

  a_special_copy: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_nrm & (is_inf | is_ind))
    |=> result_o.dest_word == $past(source_word_reg_i) && result_o.cnt_val == 18'h0
      && (result_o.infinite ^ result_o.indefinite)
  ) else $error("special operand not copied with flag");

  a_flag_with_word: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (result_o.infinite | result_o.indefinite) |-> done_o ##1 !result_o.infinite || done_o
  ) else $error("exit flag outside its result cycle");

  a_round_bit_pos: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_i & op_rn & ~is_inf & ~is_ind & (lz != 6'h00)) ##1 !uflow_q
    |-> result_o.dest_word[result_o.cnt_val[5:0] - 6'h01] == ~result_o.dest_word[59]
  ) else $error("round bit not in the vacated position");

  a_count_bound: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    iss_nrm |=> result_o.cnt_we && result_o.cnt_val <= 18'h00030 && result_o.cnt_idx == $past(instr_i.j)
  ) else $error("returned count out of range");

  a_low_exp_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_i & op_nm & (pos_coef == 48'h0) & (pos_exp == 11'h000))
    |=> result_o.dest_word == 60'h0 && result_o.cnt_val == 18'h0
  ) else $error("lowest exponent zero not cleared");

  a_refuse_unknown: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_i & ~op_known) |=> !done_o && !result_o.cnt_we
  ) else $error("unknown opcode produced a result");

  a_left_sign_fill: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_vl & cnt_neg & cnt_hi_ok & (cnt_mag != 6'h00))
    |=> result_o.dest_word[59] == $past(source_word_reg_i[59])
      && result_o.dest_word[58] == $past(source_word_reg_i[59])
  ) else $error("negative left op did not fill with the sign");

  a_right_neg_rot: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_vr & cnt_neg & cnt_hi_ok) |=> $countones(result_o.dest_word) == $countones($past(source_word_reg_i))
  ) else $error("negative right op changed the number of ones");

  a_shift_no_count: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (iss_vl | iss_vr) |=> done_o && !result_o.cnt_we && result_o.dest_idx == $past(instr_i.dest_idx)
  ) else $error("variable shift result misrouted");

  a_const_right_fill: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_i & op_cr & ({instr_i.j, instr_i.k} != 6'h00))
    |=> result_o.dest_word[59] == $past(dest_word_reg_i[59])
      && result_o.dest_word[58] == $past(dest_word_reg_i[59])
  ) else $error("constant right shift did not fill with the sign");

  a_round_sign_keep: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_i & op_rn & ~is_inf & ~is_ind) ##1 !uflow_q
    |-> result_o.dest_word[59] == $past(source_word_reg_i[59])
  ) else $error("round normalize changed the sign");

  a_flags_only_norm: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (issue_i & op_known & ~op_nm & ~op_rn) |=> !result_o.infinite && !result_o.indefinite
  ) else $error("exit flag raised by a shift");

endmodule // snu_shift_norm

/* File: tb_shift_normalize_unit_60bit.sv */
// Self-checking bench of the shift and normalize unit
`timescale 1ns/10ps
module tb_shift_normalize_unit_60bit;
  logic clk_sys_i;
  logic rst_n_i;
  logic issue_i;
  snu_pkg::snu_instr_t instr_i;
  logic [59:0] source_word_reg_i;
  logic [59:0] dest_word_reg_i;
  logic [17:0] shift_count_reg_i;
  logic done_o;
  snu_pkg::snu_result_t result_o;
  logic exit_inf;
  logic exit_ind;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  snu_shift_norm DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .instr_i(instr_i),
    .source_word_reg_i(source_word_reg_i), .dest_word_reg_i(dest_word_reg_i),
    .shift_count_reg_i(shift_count_reg_i), .done_o(done_o), .result_o(result_o));
  snu_cpu_model cpu (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .done_i(done_o), .result_i(result_o),
    .exit_inf_o(exit_inf), .exit_ind_o(exit_ind));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic conclude();
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      conclude();
    end
  end

  task automatic cmp_word(input logic [59:0] got, input logic [59:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Constant shifts take their operand from the destination and jk from the count
  task automatic issue(input logic [5:0] op, input logic [59:0] src, input logic [17:0] cnt);
    logic cs;
    cs = op[5:1] == 5'h08;
    @(posedge clk_sys_i);
    issue_i <= 1'b1;
    instr_i <= {op, 3'h5, cs ? cnt[5:3] : 3'h3, cs ? cnt[2:0] : 3'h6};
    source_word_reg_i <= cs ? ~src : src;
    dest_word_reg_i <= cs ? src : ~src;
    shift_count_reg_i <= cs ? ~cnt : cnt;
  endtask

  task automatic idle();
    @(posedge clk_sys_i);
    issue_i <= 1'b0;
  endtask

  task automatic chk(input logic [59:0] w, input logic we, input logic [17:0] c, input logic inf,
    input logic ind);
    #1;
    cmp_flag(done_o, 1'b1);
    cmp_cnt({15'h0, result_o.dest_idx}, 18'h5);
    cmp_word(result_o.dest_word, w);
    cmp_flag(result_o.cnt_we, we);
    if (we) begin
      cmp_cnt(result_o.cnt_val, c);
      cmp_cnt({15'h0, result_o.cnt_idx}, 18'h3);
    end
    cmp_flag(result_o.infinite, inf);
    cmp_flag(result_o.indefinite, ind);
  endtask

  task automatic sh(input logic [5:0] op, input logic [59:0] src, input logic [17:0] cnt,
    input logic [59:0] w);
    issue(op, src, cnt);
    idle();
    chk(w, 1'b0, 18'h0, 1'b0, 1'b0);
  endtask

  task automatic nm(input logic [5:0] op, input logic [59:0] src, input logic [59:0] w,
    input logic [17:0] c, input logic inf, input logic ind);
    issue(op, src, 18'h2a);
    idle();
    chk(w, 1'b1, c, inf, ind);
  endtask

  task automatic t_var_left();
    sh(snu_pkg::OP_VAR_LEFT, 60'h4d3d80000000049, 18'h0000a, 60'hf60000000012534);
    sh(snu_pkg::OP_VAR_LEFT, 60'h2d7c000006db512, 18'h3fff9, 60'h00b5f000001b6d4);
    sh(snu_pkg::OP_VAR_LEFT, 60'h4d3d80000000049, 18'h1f80a, 60'hf60000000012534);
    sh(snu_pkg::OP_VAR_LEFT, 60'h2d7c000006db512, 18'h207f9, 60'h00b5f000001b6d4);
    sh(snu_pkg::OP_VAR_LEFT, 60'h000000000000001, 18'h0003b, 60'h800000000000000);
    sh(snu_pkg::OP_VAR_LEFT, 60'h800000000000001, 18'h3ffc0, 60'hfffffffffffffff);
    sh(snu_pkg::OP_VAR_LEFT, 60'h800000000000001, 18'h20000, 60'h0);
  endtask

  task automatic t_var_right();
    sh(snu_pkg::OP_VAR_RIGHT, 60'h2d7c000006db512, 18'h00006, 60'h00b5f000001b6d4);
    sh(snu_pkg::OP_VAR_RIGHT, 60'h4d3d80000000049, 18'h3fff5, 60'hf60000000012534);
    sh(snu_pkg::OP_VAR_RIGHT, 60'h800000000000000, 18'h00003, 60'hf00000000000000);
    sh(snu_pkg::OP_VAR_RIGHT, 60'h800000000000000, 18'h0003f, 60'hfffffffffffffff);
    sh(snu_pkg::OP_VAR_RIGHT, 60'h2d7c000006db512, 18'h1f806, 60'h00b5f000001b6d4);
    sh(snu_pkg::OP_VAR_RIGHT, 60'h2d7c000006db512, 18'h00040, 60'h0);
  endtask

  task automatic t_const();
    sh(snu_pkg::OP_CONST_LEFT, 60'h4d3d80000000049, 18'h0000a, 60'hf60000000012534);
    sh(snu_pkg::OP_CONST_RIGHT, 60'h404fad002700004, 18'h00018, 60'h000000404fad002);
  endtask

  task automatic t_norm();
    nm(snu_pkg::OP_NORM, 60'h41c027d400004b2, 60'h4169f5000012c80, 18'h6, 1'b0, 1'b0);
    nm(snu_pkg::OP_NORM, 60'hbe3fd82bffffb4d, 60'hbe960affffed37f, 18'h6, 1'b0, 1'b0);
    nm(snu_pkg::OP_NORM, 60'h41c000000000000, 60'h0, 18'h30, 1'b0, 1'b0);
    nm(snu_pkg::OP_NORM, 60'hbe3ffffffffffff, 60'h0, 18'h30, 1'b0, 1'b0);
    nm(snu_pkg::OP_NORM, 60'h0, 60'h0, 18'h0, 1'b0, 1'b0);
    nm(snu_pkg::OP_NORM, 60'h000000000000001, 60'h0, 18'h2f, 1'b0, 1'b0);
  endtask

  task automatic t_round();
    nm(snu_pkg::OP_RND_NORM, 60'h41c027d400004b2, 60'h4169f5000012ca0, 18'h6, 1'b0, 1'b0);
    nm(snu_pkg::OP_RND_NORM, 60'hbe3fd82bffffb4d, 60'hbe960affffed35f, 18'h6, 1'b0, 1'b0);
    nm(snu_pkg::OP_RND_NORM, 60'h41c000000000000, 60'h3eb800000000000, 18'h30, 1'b0, 1'b0);
  endtask

  task automatic t_special();
    logic [11:0] top [4] = '{12'h7ff, 12'h800, 12'h3ff, 12'hc00};
    logic [59:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {top[i % 4], 48'h123456789abc};
      nm(i < 4 ? snu_pkg::OP_NORM : snu_pkg::OP_RND_NORM, w, w, 18'h0, i % 4 < 2, i % 4 >= 2);
    end
    idle();
    #1;
    cmp_flag(result_o.infinite, 1'b0);
    cmp_flag(result_o.indefinite, 1'b0);
  endtask

  // Two issues back to back, then an unknown opcode that must be ignored
  task automatic t_b2b();
    issue(snu_pkg::OP_VAR_LEFT, 60'h4d3d80000000049, 18'h0000a);
    issue(snu_pkg::OP_NORM, 60'h41c027d400004b2, 18'h0);
    chk(60'hf60000000012534, 1'b0, 18'h0, 1'b0, 1'b0);
    issue(6'h16, 60'h7ff000000000000, 18'h0);
    chk(60'h4169f5000012c80, 1'b1, 18'h6, 1'b0, 1'b0);
    idle();
    #1;
    cmp_flag(done_o, 1'b0);
    cmp_cnt(cpu.count_file[3], 18'h6);
    cmp_flag(exit_inf, 1'b1);
    cmp_flag(exit_ind, 1'b1);
  endtask

  initial begin
    rst_n_i = 1'b0;
    issue_i = 1'b0;
    instr_i = '0;
    source_word_reg_i = 60'h0;
    dest_word_reg_i = 60'h0;
    shift_count_reg_i = 18'h0;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    cmp_flag(done_o, 1'b0);
    cmp_word(result_o.dest_word, 60'h0);
    t_var_left();
    t_var_right();
    t_const();
    t_norm();
    t_round();
    t_special();
    t_b2b();
    conclude();
  end
endmodule // tb_shift_normalize_unit_60bit
